/* File: sdcal_host_mdl.sv */
// Purpose: Host model for mode writes, coefficient access and data reads
// Assumes: Requests change one time unit after a rising clock edge
// Notes: Each request is held for exactly one sampling edge
`timescale 1ns/10ps
module sdcal_host_mdl (
	// Clock
	input wire logic clk_i,
	// Mode select
	output logic op_wr_o,
	output logic [2:0] op_o,
	// Coefficients and data
	output sdcal_pkg::sdcal_coef_req_s coef_o,
	input wire logic [23:0] rdata_i,
	output logic data_read_o
);
	initial begin
		op_wr_o = 1'b0;
		op_o = 3'h0;
		coef_o = '0;
		data_read_o = 1'b0;
	end
	// ==========================================================
	// Host requests
	task op_write(input logic [2:0] code);
		op_o = code;
		op_wr_o = 1'b1;
		@(posedge clk_i) #1;
		op_wr_o = 1'b0;
	endtask
	task coef_acc(input logic wr, input logic kind, input logic [1:0] ch,
		input logic [23:0] wd, output logic [23:0] rd);
		coef_o = '{wr, kind, ch, wd};
		@(posedge clk_i) #1;
		coef_o.wr = 1'b0;
		rd = rdata_i;
		// Idle edge so a following call never rewrites the strobe at once
		@(posedge clk_i) #1;
	endtask
	task read_ack();
		data_read_o = 1'b1;
		@(posedge clk_i) #1;
		data_read_o = 1'b0;
	endtask
endmodule // sdcal_host_mdl

/* File: sdcal_pkg.sv */
// Purpose: Constants, modes and state layout of the sinc3 calibrated filter
// Assumes: Modulator bit arrives once per MOD_DIV system clocks
// Notes: Coefficient words are 24 bits, datapath is 33 bits
package sdcal_pkg;
	// ==========================================================
	// Timing
	localparam int REF_CLK_HZ = 2457600;
	localparam int MOD_RATE_HZ = 19200;
	localparam int MOD_DIV = REF_CLK_HZ / MOD_RATE_HZ;
	localparam int MOD_CNT_W = $clog2(MOD_DIV);
	localparam int SETTLE_PERIODS = 3;
	// ==========================================================
	// Widths
	localparam int NOTCH_W = 12;
	localparam int CHANNELS = 3;
	localparam int CH_W = 2;
	localparam int COEF_SETS = 1 << CH_W;
	localparam int COEF_W = 24;
	localparam int DP_W = 33;
	localparam int CIC_W = 37;
	localparam int QUO_W = 24;
	localparam int GAIN_SH = 22;
	// ==========================================================
	// Values
	localparam logic [23:0] ZS_RST = 24'h000000;
	localparam logic [23:0] FS_RST = 24'h400000;
	localparam logic [23:0] CODE_MAX = 24'hffffff;
	localparam logic [23:0] SPOS_MAX = 24'h7fffff;
	localparam logic signed [32:0] MID_CODE = 33'h000800000;
	localparam logic signed [32:0] CODE_MAX33 = 33'h000ffffff;
	localparam logic signed [32:0] GAIN_NUM = 33'h000400000;
	// ==========================================================
	// Operating mode select codes
	localparam logic [2:0] OP_NORMAL = 3'h0;
	localparam logic [2:0] OP_SELF = 3'h1;
	localparam logic [2:0] OP_ZS_SYS = 3'h2;
	localparam logic [2:0] OP_FS_SYS = 3'h3;
	localparam logic [2:0] OP_ZS_SELF = 3'h6;
	localparam logic [2:0] OP_FS_SELF = 3'h7;

	typedef enum logic [1:0] {SDCAL_RUN, SDCAL_ZCAL, SDCAL_FCAL} sdcal_mode_e;
	typedef enum logic {SDCAL_DIV_CONV, SDCAL_DIV_GAIN} sdcal_divk_e;

	typedef struct packed {
		logic wr;
		logic kind;
		logic [CH_W-1:0] chan;
		logic [COEF_W-1:0] wdata;
	} sdcal_coef_req_s;

	typedef struct packed {
		logic mod_s1;
		logic mod_s2;
		logic frs_s1;
		logic frs_s2;
		logic [MOD_CNT_W-1:0] pcnt;
		logic [NOTCH_W-1:0] dcnt;
		logic [CIC_W-1:0] i1;
		logic [CIC_W-1:0] i2;
		logic [CIC_W-1:0] i3;
		logic [CIC_W-1:0] d1;
		logic [CIC_W-1:0] d2;
		logic [CIC_W-1:0] d3;
		logic [1:0] settle;
		sdcal_mode_e mode;
		logic selfcal;
		logic fullseq;
		logic [2:0] op;
		logic [CH_W-1:0] chan;
		logic div_busy;
		sdcal_divk_e div_kind;
		logic div_neg;
		logic [4:0] div_cnt;
		logic [CIC_W:0] rem;
		logic [CIC_W-1:0] den;
		logic [QUO_W-1:0] quo;
		logic [COEF_SETS-1:0][COEF_W-1:0] zs;
		logic [COEF_SETS-1:0][COEF_W-1:0] fs;
		logic [COEF_W-1:0] data;
		logic [COEF_W-1:0] rdata;
		logic new_word_flag_n_n;
	} sdcal_state_s;
endpackage

/* File: sdcal_top.sv */
// Purpose: Sinc3 decimator with offset and gain calibration
// Assumes: One system clock; modulator bit and restart pin are asynchronous
// Notes: Coefficients are per channel; result is offset binary or unipolar
// What this block does
// R1 - Filter is three cascaded length-N moving sums, each normalised by N.
// R2 - One output word per N times 128 clocks, N from notch word.
// R3 - Modulator sample taken once per 128 clocks.
// R4 - Decimate to the output rate; N moves notches, shape stays.
// R5 - Unsynchronised steps may take up to four periods to settle.
// R6 - Restart pin or software restart settles in exactly three periods.
// R7 - Channel change restarts filter, no data update for three periods.
// R8 - A calibration code written to mode bits starts calibration anytime.
// R9 - Host should recalibrate after gain, notch, range, temperature changes.
// R10 - Zero and full-scale coefficients are 24 bits, host readable, writable.
// R11 - Offset coefficient is subtracted before the gain correction.
// R12 - Offset-corrected result is multiplied by normalised full-scale factor.
// R13 - Zero-scale calibration result stored for the selected channel.
// R14 - Full-scale calibration result stored for the selected channel.
// R15 - Datapath carries 33 bits; result delivered as 16 or 24 bits.
// R16 - Mode code 0,0,1 starts full self-calibration.
// R17 - Mode bits return to 0,0,0 when calibration finishes.
// R18 - Data-ready goes inactive at calibration start until a new word.
// R19 - Polarity changes only output coding, not calibration points.
// R20 - Out-of-range corrected results saturate to minimum or maximum code.
`timescale 1ns/10ps
module sdcal_top (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Modulator and filter control
	input wire logic mod_bit_i,
	input wire logic [sdcal_pkg::NOTCH_W-1:0] notch_word_i,
	input wire logic filter_restart_bit_i,
	input wire logic sw_restart_i,
	input wire logic [sdcal_pkg::CH_W-1:0] chan_i,
	input wire logic bipolar_i,
	input wire logic word24_i,
	// Operating mode select
	input wire logic op_select_wr_i,
	input wire logic op_select_bit2_i,
	input wire logic op_select_bit1_i,
	input wire logic op_select_bit0_i,
	output wire logic op_select_bit2_o,
	output wire logic op_select_bit1_o,
	output wire logic op_select_bit0_o,
	// Coefficient access
	input wire sdcal_pkg::sdcal_coef_req_s coef_i,
	output wire logic [sdcal_pkg::COEF_W-1:0] coef_rdata_o,
	// Conversion result and status
	input wire logic data_read_i,
	output wire logic [sdcal_pkg::COEF_W-1:0] data_o,
	output wire logic new_word_flag_n_o,
	output wire logic cal_zero_o,
	output wire logic cal_full_o,
	output wire logic cal_self_o
);
	localparam int CW = sdcal_pkg::CIC_W;
	localparam int QW = sdcal_pkg::QUO_W;

	sdcal_pkg::sdcal_state_s q;
	sdcal_pkg::sdcal_state_s n;
	logic [2:0] code;
	logic cal_wr;
	logic chg;
	logic ext_rst;
	logic restart;
	logic smp;
	logic dec;
	logic take;
	logic [CW-1:0] step;
	logic [CW-1:0] c1;
	logic [CW-1:0] c2;
	logic [CW-1:0] c3;
	logic [CW-1:0] mag;
	logic [12:0] nval;
	logic [CW-1:0] n3;
	logic ge;
	logic [CW:0] rsub;
	logic [QW-1:0] nquo;
	logic last;
	logic signed [24:0] sval;
	logic [23:0] s24;
	logic [23:0] zcoef;
	logic [23:0] gcoef;
	logic signed [32:0] diff;
	logic signed [57:0] prod;
	logic signed [32:0] corr;
	logic signed [32:0] t;
	logic sat_hi;
	logic sat_lo;
	logic [23:0] code24;
	logic [23:0] fmt;
	logic done;
	logic upd;
	logic zcap;
	logic fmeas;
	logic gdone;
	logic finish;

	// ==========================================================
	// Next state
	always_comb begin
		n = q;
		n.mod_s1 = mod_bit_i;
		n.mod_s2 = q.mod_s1;
		n.frs_s1 = filter_restart_bit_i;
		n.frs_s2 = q.frs_s1;
		code = {op_select_bit2_i, op_select_bit1_i, op_select_bit0_i};
		cal_wr = op_select_wr_i && (code == sdcal_pkg::OP_SELF
			|| code == sdcal_pkg::OP_ZS_SYS || code == sdcal_pkg::OP_FS_SYS
			|| code == sdcal_pkg::OP_ZS_SELF
			|| code == sdcal_pkg::OP_FS_SELF); // [R8] [R16]
		chg = chan_i != q.chan;
		ext_rst = q.frs_s2 || sw_restart_i || chg || cal_wr; // [R6] [R7]
		restart = ext_rst;
		// Modulator sample and decimation strobes
		smp = q.pcnt == sdcal_pkg::MOD_CNT_W'(sdcal_pkg::MOD_DIV - 1); // [R3]
		dec = smp && (q.dcnt == notch_word_i - 12'h001); // [R2] [R4]
		n.pcnt = smp ? '0 : q.pcnt + 1'b1;
		if (smp) begin
			n.dcnt = dec ? '0 : q.dcnt + 1'b1;
		end
		// Integrators at sample rate, combs at output rate
		// Combs see this sample, so the third word after restart is whole
		step = q.mod_s2 ? CW'(1) : '1;
		if (smp) begin
			n.i1 = q.i1 + step; // [R1]
			n.i2 = q.i2 + n.i1;
			n.i3 = q.i3 + n.i2;
		end
		c1 = n.i3 - q.d1;
		c2 = c1 - q.d2;
		c3 = c2 - q.d3;
		take = 1'b0;
		if (dec) begin
			n.d1 = n.i3; // [R1]
			n.d2 = c1;
			n.d3 = c2;
			if (q.settle != 2'h3) begin
				n.settle = q.settle + 2'h1;
			end
			// Third word after a restart is the first settled one
			take = q.settle >= 2'(sdcal_pkg::SETTLE_PERIODS - 1); // [R5] [R6]
		end
		// Serial fractional divider, one quotient bit per clock
		mag = c3[CW-1] ? -c3 : c3;
		// Notch word of zero stands for 4096
		nval = (notch_word_i == '0) ? {1'b1, 12'h000}
			: {1'b0, notch_word_i};
		n3 = CW'(nval) * CW'(nval) * CW'(nval);
		ge = q.rem >= {1'b0, q.den};
		rsub = ge ? q.rem - {1'b0, q.den} : q.rem;
		nquo = {q.quo[QW-2:0], ge};
		last = q.div_busy && (q.div_cnt == 5'(QW - 1));
		if (q.div_busy) begin
			n.rem = {rsub[CW-1:0], 1'b0};
			n.quo = nquo;
			n.div_cnt = q.div_cnt + 5'h01;
			if (last) begin
				n.div_busy = 1'b0;
			end
		end
		// Normalised filter result and correction
		sval = q.div_neg ? -$signed({1'b0, nquo}) : $signed({1'b0, nquo}); // [R1]
		s24 = (!sval[24] && sval[23]) ? sdcal_pkg::SPOS_MAX : sval[23:0];
		zcoef = q.zs[q.chan];
		gcoef = q.fs[q.chan];
		diff = {{8{sval[24]}}, sval} - {{9{zcoef[23]}}, zcoef}; // [R11] [R15]
		prod = diff * $signed({1'b0, gcoef}); // [R12]
		corr = $signed(prod[sdcal_pkg::GAIN_SH+sdcal_pkg::DP_W-1:
			sdcal_pkg::GAIN_SH]); // [R15]
		t = bipolar_i ? corr + sdcal_pkg::MID_CODE : corr <<< 1; // [R19]
		sat_hi = t > sdcal_pkg::CODE_MAX33;
		sat_lo = t < 0;
		code24 = sat_hi ? sdcal_pkg::CODE_MAX
			: (sat_lo ? 24'h000000 : t[23:0]); // [R20]
		fmt = word24_i ? code24 : {8'h00, code24[23:8]}; // [R15]
		done = last && !ext_rst;
		upd = done && q.div_kind == sdcal_pkg::SDCAL_DIV_CONV
			&& q.mode == sdcal_pkg::SDCAL_RUN;
		zcap = done && q.div_kind == sdcal_pkg::SDCAL_DIV_CONV
			&& q.mode == sdcal_pkg::SDCAL_ZCAL;
		fmeas = done && q.div_kind == sdcal_pkg::SDCAL_DIV_CONV
			&& q.mode == sdcal_pkg::SDCAL_FCAL;
		gdone = done && q.div_kind == sdcal_pkg::SDCAL_DIV_GAIN;
		finish = 1'b0;
		// Host coefficient access, overridden by a capture
		if (coef_i.wr) begin
			if (coef_i.kind) begin
				n.fs[coef_i.chan] = coef_i.wdata; // [R10]
			end else begin
				n.zs[coef_i.chan] = coef_i.wdata; // [R10]
			end
		end
		n.rdata = coef_i.kind ? q.fs[coef_i.chan] : q.zs[coef_i.chan]; // [R10]
		if (data_read_i) begin
			n.new_word_flag_n_n = 1'b1;
		end
		if (upd) begin
			n.data = fmt; // [R7]
			n.new_word_flag_n_n = 1'b0; // [R18]
		end
		if (zcap) begin
			n.zs[q.chan] = s24; // [R13]
			if (q.fullseq) begin
				n.mode = sdcal_pkg::SDCAL_FCAL;
				restart = 1'b1;
			end else begin
				finish = 1'b1;
			end
		end
		if (fmeas) begin
			if (diff < sdcal_pkg::GAIN_NUM) begin
				n.fs[q.chan] = sdcal_pkg::CODE_MAX; // [R14] [R20]
				finish = 1'b1;
			end else begin
				// Reciprocal of the measured span gives the gain factor
				n.div_busy = 1'b1;
				n.div_cnt = '0;
				n.quo = '0;
				n.div_neg = 1'b0;
				n.div_kind = sdcal_pkg::SDCAL_DIV_GAIN;
				n.rem = {5'h00, sdcal_pkg::GAIN_NUM};
				n.den = {4'h0, diff};
			end
		end
		if (gdone) begin
			n.fs[q.chan] = nquo; // [R14]
			finish = 1'b1;
		end
		if (finish) begin
			n.mode = sdcal_pkg::SDCAL_RUN;
			n.op = sdcal_pkg::OP_NORMAL; // [R17]
			n.fullseq = 1'b0;
			restart = q.selfcal;
		end
		if (take && !ext_rst) begin
			n.div_busy = 1'b1;
			n.div_cnt = '0;
			n.quo = '0;
			n.div_neg = c3[CW-1];
			n.div_kind = sdcal_pkg::SDCAL_DIV_CONV;
			n.rem = {1'b0, mag};
			n.den = n3;
		end
		if (op_select_wr_i) begin
			n.op = code;
			n.mode = sdcal_pkg::SDCAL_RUN;
			n.fullseq = 1'b0;
			if (cal_wr) begin
				n.mode = (code == sdcal_pkg::OP_FS_SYS
					|| code == sdcal_pkg::OP_FS_SELF)
					? sdcal_pkg::SDCAL_FCAL : sdcal_pkg::SDCAL_ZCAL; // [R8]
				n.fullseq = code == sdcal_pkg::OP_SELF; // [R16]
				n.selfcal = code == sdcal_pkg::OP_SELF || code[2];
				n.new_word_flag_n_n = 1'b1; // [R18]
			end
		end
		n.chan = chan_i;
		if (restart) begin
			n.i1 = '0; // [R6] [R7]
			n.i2 = '0;
			n.i3 = '0;
			n.d1 = '0;
			n.d2 = '0;
			n.d3 = '0;
			n.dcnt = '0;
			n.settle = '0;
			n.div_busy = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.mode <= sdcal_pkg::SDCAL_RUN;
			q.div_kind <= sdcal_pkg::SDCAL_DIV_CONV;
			q.zs <= {sdcal_pkg::COEF_SETS{sdcal_pkg::ZS_RST}};
			q.fs <= {sdcal_pkg::COEF_SETS{sdcal_pkg::FS_RST}};
			q.new_word_flag_n_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign {op_select_bit2_o, op_select_bit1_o, op_select_bit0_o} = q.op;
	assign coef_rdata_o = q.rdata;
	assign data_o = q.data;
	assign new_word_flag_n_o = q.new_word_flag_n_n;
	assign cal_zero_o = q.mode == sdcal_pkg::SDCAL_ZCAL;
	assign cal_full_o = q.mode == sdcal_pkg::SDCAL_FCAL;
	assign cal_self_o = q.selfcal && q.mode != sdcal_pkg::SDCAL_RUN;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_cal_wr;
		cal_wr;
	endsequence
	sequence s_cal_end;
		(q.mode != sdcal_pkg::SDCAL_RUN && !op_select_wr_i)
			##1 (q.mode == sdcal_pkg::SDCAL_RUN);
	endsequence

	AST_MOD_PERIOD: assert property (smp |-> ##128 smp) // [R3]
		else $error("modulator sample spacing wrong");
	AST_CAL_NEW_WORD_FLAG_N: assert property (s_cal_wr |=> new_word_flag_n_o) // [R18]
		else $error("data ready active after calibration start");
	AST_CAL_ENTER: assert property (s_cal_wr |=> q.mode != sdcal_pkg::SDCAL_RUN) // [R8]
		else $error("calibration not started");
	AST_OP_DONE: assert property (s_cal_end |-> q.op == sdcal_pkg::OP_NORMAL) // [R17]
		else $error("mode bits not cleared after calibration");
	AST_RESTART: assert property (ext_rst |=> q.settle == 2'h0 && q.i3 == '0 && !q.div_busy) // [R6]
		else $error("filter not restarted");
	AST_SETTLE: assert property (upd |-> q.settle == 2'h3) // [R7]
		else $error("data updated before settling");
	AST_NEW_WORD_FLAG_N_LOW: assert property (upd |=> !new_word_flag_n_o && data_o == $past(fmt)) // [R18]
		else $error("new word not flagged");
	AST_ZS_STORE: assert property (zcap |=> q.zs[$past(q.chan)] == $past(s24)) // [R13]
		else $error("zero-scale coefficient not stored");
	AST_FS_STORE: assert property (gdone |=> q.fs[$past(q.chan)] == $past(nquo)) // [R14]
		else $error("full-scale coefficient not stored");
	AST_SAT: assert property (upd && sat_hi && word24_i |=> data_o == sdcal_pkg::CODE_MAX) // [R20]
		else $error("high result not saturated");
	AST_COEF_WR: assert property (coef_i.wr && !coef_i.kind && !zcap |=> q.zs[$past(coef_i.chan)] == $past(coef_i.wdata)) // [R10]
		else $error("host coefficient write lost");
endmodule // sdcal_top

/* File: sdcal_top_tb_top.sv */
// Purpose: Self-checking bench for the calibrated sinc3 filter
// Assumes: N of 2, so one output period is 256 clocks
// Notes: Bench acts as modulator; alternating bits read as zero input
`timescale 1ns/10ps
module sdcal_top_tb_top;
	localparam int PER = 256;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic mod_bit_i = 1'b0;
	logic frs = 1'b0;
	logic sws = 1'b0;
	logic [1:0] chan = 2'h0;
	logic bip = 1'b1;
	logic w24 = 1'b1;
	logic [1:0] pat = 2'h0;
	logic [7:0] mc = 8'h00;
	logic op_wr, drd, flag_n, cz, cf, cs;
	logic [2:0] op, op_q;
	logic [23:0] rdat, dat, q;
	sdcal_pkg::sdcal_coef_req_s coef;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	// ==========================================================
	// Modulator and front end: self cal zero alternates, self cal full drives all ones
	always @(posedge sys_clk_i) begin
		mc <= mc + 8'h01;
		mod_bit_i <= #1 (cf & cs) | (((cz & cs) | pat[1]) ? mc[7] : pat[0]);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			complete_run();
		end
	end
	sdcal_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.mod_bit_i(mod_bit_i), .notch_word_i(12'h002),
		.filter_restart_bit_i(frs), .sw_restart_i(sws), .chan_i(chan),
		.bipolar_i(bip), .word24_i(w24), .op_select_wr_i(op_wr),
		.op_select_bit2_i(op[2]), .op_select_bit1_i(op[1]),
		.op_select_bit0_i(op[0]), .op_select_bit2_o(op_q[2]),
		.op_select_bit1_o(op_q[1]), .op_select_bit0_o(op_q[0]),
		.coef_i(coef), .coef_rdata_o(rdat), .data_read_i(drd),
		.data_o(dat), .new_word_flag_n_o(flag_n), .cal_zero_o(cz),
		.cal_full_o(cf), .cal_self_o(cs));
	sdcal_host_mdl host (.clk_i(sys_clk_i), .op_wr_o(op_wr), .op_o(op),
		.coef_o(coef), .rdata_i(rdat), .data_read_o(drd));
	// ==========================================================
	// Helpers
	task chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cchk(input logic kind, input logic [1:0] ch, input logic [23:0] e);
		host.coef_acc(1'b0, kind, ch, 24'h000000, q);
		chk(q, e);
	endtask
	task wait_word(output int k);
		k = 0;
		while (flag_n !== 1'b0 && k < 4000) begin
			@(posedge sys_clk_i) #1;
			k++;
		end
	endtask
	task wait_op(output int k);
		k = 0;
		while (op_q !== 3'h0 && k < 4000) begin
			@(posedge sys_clk_i) #1;
			k++;
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task coef_rw();
		cchk(1'b0, 2'h0, 24'h000000);
		cchk(1'b1, 2'h0, 24'h400000);
		host.coef_acc(1'b1, 1'b0, 2'h3, 24'h123456, q);
		host.coef_acc(1'b1, 1'b1, 2'h3, 24'h654321, q);
		cchk(1'b0, 2'h3, 24'h123456);
		cchk(1'b1, 2'h3, 24'h654321);
		cchk(1'b0, 2'h2, 24'h000000);
		$display("coefficient test done");
	endtask
	task conv(input logic [1:0] p, input logic b, input logic w,
		input int how, input logic [23:0] exp);
		int k;
		pat = p;
		bip = b;
		w24 = w;
		if (how == 2) chan = chan + 2'h1;
		else if (how == 1) frs = 1'b1;
		else sws = 1'b1;
		repeat (3) @(posedge sys_clk_i) #1;
		frs = 1'b0;
		sws = 1'b0;
		host.read_ack();
		wait_word(k);
		chk(24'(k > 3 * PER - 140 && k < 3 * PER + 100), 24'h1);
		chk(dat, exp);
		host.read_ack();
		wait_word(k);
		chk(24'(k), 24'(PER - 1));
		$display("conversion test done");
	endtask
	task cal_self();
		int k;
		chan = 2'h1;
		pat = 2'h1;
		bip = 1'b1;
		w24 = 1'b1;
		host.coef_acc(1'b1, 1'b0, 2'h1, 24'h0a0a0a, q);
		host.coef_acc(1'b1, 1'b1, 2'h1, 24'h0b0b0b, q);
		host.op_write(3'h1);
		@(posedge sys_clk_i) #1;
		chk(24'({cz, cf, cs, flag_n, op_q}), 24'h59);
		wait_op(k);
		chk(24'(k > 6 * PER - 300 && k < 6 * PER + 200), 24'h1);
		cchk(1'b0, 2'h1, 24'h000000);
		cchk(1'b1, 2'h1, 24'h400000);
		wait_word(k);
		chk(dat, 24'hffffff);
		$display("self calibration test done");
	endtask
	task cal_parts();
		int k;
		chan = 2'h3;
		host.op_write(3'h6);
		chk(24'({cz, cf, cs, op_q}), 24'h00002e);
		wait_op(k);
		chk(24'(k < 3 * PER + 200), 24'h1);
		cchk(1'b0, 2'h3, 24'h000000);
		host.op_write(3'h7);
		chk(24'({cz, cf, cs, op_q}), 24'h00001f);
		wait_op(k);
		chk(24'(k < 3 * PER + 200), 24'h1);
		cchk(1'b1, 2'h3, 24'h400000);
		cchk(1'b0, 2'h3, 24'h000000);
		host.op_write(3'h6);
		@(posedge sys_clk_i) #1;
		host.op_write(3'h4);
		chk(24'({cz, cf, op_q}), 24'h000004);
		@(posedge sys_clk_i) #1;
		$display("partial calibration test done");
	endtask
	task cal_sys();
		int k;
		chan = 2'h2;
		pat = 2'h0;
		host.op_write(3'h2);
		wait_op(k);
		pat = 2'h1;
		host.op_write(3'h3);
		wait_op(k);
		chk(24'(k < 3 * PER + 200), 24'h1);
		cchk(1'b0, 2'h2, 24'h800000);
		cchk(1'b1, 2'h2, 24'h200000);
		$display("system calibration test done");
		conv(2'h2, 1'b1, 1'b1, 0, 24'hc00000);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		chk(24'({dat, flag_n, op_q}), 24'h000008);
		coef_rw();
		conv(2'h1, 1'b1, 1'b1, 0, 24'hffffff);
		conv(2'h0, 1'b1, 1'b1, 1, 24'h000000);
		conv(2'h2, 1'b1, 1'b1, 2, 24'h800000);
		conv(2'h2, 1'b0, 1'b1, 0, 24'h000000);
		conv(2'h2, 1'b1, 1'b0, 0, 24'h008000);
		conv(2'h1, 1'b0, 1'b0, 1, 24'h00ffff);
		cal_self();
		cal_parts();
		cal_sys();
		complete_run();
	end
endmodule // sdcal_top_tb_top
